// file: design/ide_map.svh
`ifndef IDE_MAP_SVH
`define IDE_MAP_SVH
// opcode class patterns (bits 13:8, IDE_TOP_JUMP bits 13:12) and core constants
`define IDE_OP_DEC_SKIP 6'h0b
`define IDE_OP_INC_SKIP 6'h0f
`define IDE_OP_INC 6'h0a
`define IDE_OP_OR_FILE 6'h04
`define IDE_OP_MOVE_FW 6'h08
`define IDE_OP_OR_LIT 6'h1a
`define IDE_OP_LOAD_LIT 6'h19
`define IDE_OP_STORE 6'h00
`define IDE_TOP_JUMP 2'h3
`define IDE_PC_RESET 12'h000
`define IDE_ACC_RESET 8'h00
`define IDE_ONE 8'h01
`define IDE_ZERO 8'h00
`define IDE_FULL 8'hff
`define IDE_PC_STEP 12'h001
`endif

// file: design/ide_pkg.sv
package ide_pkg;
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } ide_file_wr_t;
    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } ide_spec_wr_t;
endpackage : ide_pkg

// file: design/ide_core.sv
// Overview of operation
// RQ1 - decrement-skip subtracts one from file, routes by d, flags unchanged
// RQ2 - decrement-skip zero result replaces next instruction with no_operation, two cycles
// RQ3 - increment-skip adds one, routes by d, zero skips next, no flags
// RQ4 - jump_abs loads 12-bit immediate into program_counter, no flags
// RQ5 - inc_file adds one to file, updates zero flag, one cycle
// RQ6 - destination bit 0 writes accumulator, 1 writes back file register
// RQ7 - or_literal_acc ORs literal into accumulator, updates zero flag, one cycle
// RQ8 - or_acc_file ORs accumulator with file, routes by d, updates zero flag
// RQ9 - move_file_to_acc copies file to accumulator, flags untouched
// RQ10 - load_literal_acc puts literal in accumulator, flags untouched
// RQ11 - store_acc_file writes accumulator to 7-bit file address, no flags
// RQ12 - store_acc_special writes accumulator to 6-bit special address, no flags
// RQ13 - jump_abs takes two cycles by flushing the fetched instruction
// RQ14 - instructions without listed flags hold zero flag unchanged
`timescale 1ns/100ps
`default_nettype none
`include "ide_map.svh"
module ide_core
    import ide_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [13:0] i_instr,
    input wire logic [7:0] i_file_rdata,
    output logic [6:0] o_file_raddr,
    output ide_pkg::ide_file_wr_t o_file_wr,
    output ide_pkg::ide_spec_wr_t o_spec_wr,
    output logic [11:0] o_pc,
    output logic [7:0] o_acc,
    output logic o_zero_flag,
    output logic o_flush
);
    import ide_pkg::*;

    logic [11:0] pc_ff;
    logic [11:0] nxt_pc;
    logic [7:0] acc_ff;
    logic [7:0] nxt_acc;
    logic zero_ff;
    logic nxt_zero;
    logic flush_ff;
    logic nxt_flush;
    // set by a jump so the flush slot keeps the counter on the target
    logic jump_hold_ff;
    logic nxt_jump_hold;
    ide_file_wr_t fwr_ff;
    ide_file_wr_t nxt_fwr;
    ide_spec_wr_t swr_ff;
    ide_spec_wr_t nxt_swr;
    logic [5:0] op_hi;
    logic dest_bit;
    logic [7:0] result;
    logic has_result;
    logic is_skip;
    logic is_jump;

    function automatic logic op_is(input logic [13:0] ins, input logic [5:0] pat);
        op_is = (ins[13:8] == pat);
    endfunction : op_is

    assign op_hi = i_instr[13:8];
    assign dest_bit = i_instr[7];
    // file address presented combinationally so read data is ready in the same cycle
    assign o_file_raddr = i_instr[6:0];
    assign is_jump = (i_instr[13:12] == `IDE_TOP_JUMP);
    assign is_skip = op_is(i_instr, `IDE_OP_DEC_SKIP) || op_is(i_instr, `IDE_OP_INC_SKIP);

    always_comb begin
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        nxt_fwr = '0;
        nxt_swr = '0;
        nxt_flush = 1'b0;
        nxt_jump_hold = 1'b0;
        nxt_pc = pc_ff + `IDE_PC_STEP;
        result = `IDE_ZERO;
        has_result = 1'b0;
        // a flushed slot runs as no_operation; only the counter moves, stepping by one or holding after a jump
        if (!flush_ff) begin
            if (is_jump) begin
                // RQ4 jump target load
                nxt_pc = i_instr[11:0];
                // RQ13 flush after jump
                nxt_flush = 1'b1;
                nxt_jump_hold = 1'b1;
            end else begin
                unique case (op_hi)
                    // RQ1 decrement result
                    `IDE_OP_DEC_SKIP: begin
                        result = i_file_rdata - `IDE_ONE;
                        has_result = 1'b1;
                    end
                    // RQ3 increment result
                    `IDE_OP_INC_SKIP: begin
                        result = i_file_rdata + `IDE_ONE;
                        has_result = 1'b1;
                    end
                    // RQ5 increment with zero flag
                    `IDE_OP_INC: begin
                        result = i_file_rdata + `IDE_ONE;
                        has_result = 1'b1;
                        nxt_zero = (result == `IDE_ZERO);
                    end
                    // RQ8 or with file
                    `IDE_OP_OR_FILE: begin
                        result = acc_ff | i_file_rdata;
                        has_result = 1'b1;
                        nxt_zero = (result == `IDE_ZERO);
                    end
                    `IDE_OP_MOVE_FW: begin
                        // RQ9 file to accumulator; d=1 is a different opcode, ignored
                        if (!dest_bit) begin
                            nxt_acc = i_file_rdata;
                        end
                    end
                    // RQ7 or literal
                    `IDE_OP_OR_LIT: begin
                        nxt_acc = acc_ff | i_instr[7:0];
                        nxt_zero = (nxt_acc == `IDE_ZERO);
                    end
                    // RQ10 literal load
                    `IDE_OP_LOAD_LIT: begin
                        nxt_acc = i_instr[7:0];
                    end
                    `IDE_OP_STORE: begin
                        if (dest_bit) begin
                            // RQ11 store to file
                            nxt_fwr = '{we: 1'b1, addr: i_instr[6:0], data: acc_ff};
                        end else if (i_instr[6] == 1'b0) begin
                            // RQ12 store to special register
                            nxt_swr = '{we: 1'b1, addr: i_instr[5:0], data: acc_ff};
                        end
                    end
                    default: begin
                        // instructions outside this subset pass as no_operation
                    end
                endcase
                // RQ6 destination routing
                if (has_result) begin
                    if (dest_bit) begin
                        nxt_fwr = '{we: 1'b1, addr: i_instr[6:0], data: result};
                    end else begin
                        nxt_acc = result;
                    end
                end
                // RQ2 skip on zero
                if (is_skip && result == `IDE_ZERO) begin
                    nxt_flush = 1'b1;
                end
            end
        end else if (jump_hold_ff) begin
            // RQ13 slot after a jump holds the counter
            // the target word is already presented; stepping here would lose it
            nxt_pc = pc_ff;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pc_ff <= `IDE_PC_RESET;
            flush_ff <= 1'b0;
            jump_hold_ff <= 1'b0;
        end else begin
            pc_ff <= nxt_pc;
            flush_ff <= nxt_flush;
            jump_hold_ff <= nxt_jump_hold;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            acc_ff <= `IDE_ACC_RESET;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // RQ14 flag hold
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            zero_ff <= 1'b0;
        end else begin
            zero_ff <= nxt_zero;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            fwr_ff <= '0;
            swr_ff <= '0;
        end else begin
            fwr_ff <= nxt_fwr;
            swr_ff <= nxt_swr;
        end
    end

    assign o_pc = pc_ff;
    assign o_acc = acc_ff;
    assign o_zero_flag = zero_ff;
    assign o_file_wr = fwr_ff;
    assign o_spec_wr = swr_ff;
    assign o_flush = flush_ff;

    sequence s_dec_zero;
        !flush_ff && op_is(i_instr, `IDE_OP_DEC_SKIP) && i_file_rdata == `IDE_ONE;
    endsequence

    sequence s_inc_zero;
        !flush_ff && op_is(i_instr, `IDE_OP_INC_SKIP) && i_file_rdata == `IDE_FULL;
    endsequence

    sequence s_jump_taken;
        !flush_ff && is_jump;
    endsequence

    a_dec_skip_flush: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ2
        s_dec_zero |=> flush_ff ##1 !flush_ff)
        else $error("decrement to zero did not skip exactly one slot");

    a_inc_skip_flush: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ3
        s_inc_zero |=> flush_ff)
        else $error("increment to zero did not skip");

    a_dec_no_skip: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ1
        !flush_ff && op_is(i_instr, `IDE_OP_DEC_SKIP) && i_file_rdata != `IDE_ONE
        |=> !flush_ff && zero_ff == $past(zero_ff))
        else $error("decrement skipped or changed flags");

    a_jump_target: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ4
        !flush_ff && is_jump |=> pc_ff == $past(i_instr[11:0]) && flush_ff)
        else $error("jump target not loaded");

    a_jump_two_cycle: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ13
        s_jump_taken ##1 1'b1 |=> pc_ff == $past(pc_ff) && !flush_ff)
        else $error("jump flush slot did not hold counter on target");

    a_inc_zero_flag: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ5
        !flush_ff && op_is(i_instr, `IDE_OP_INC) |=> zero_ff == ($past(i_file_rdata) == `IDE_FULL))
        else $error("increment zero flag wrong");

    a_dest_file: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ6
        !flush_ff && op_is(i_instr, `IDE_OP_INC) && dest_bit
        |=> fwr_ff.we && acc_ff == $past(acc_ff))
        else $error("d=1 result not written to file");

    a_or_literal: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ7
        !flush_ff && op_is(i_instr, `IDE_OP_OR_LIT)
        |=> acc_ff == ($past(acc_ff) | $past(i_instr[7:0])))
        else $error("or literal result wrong");

    a_or_file: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ8
        !flush_ff && op_is(i_instr, `IDE_OP_OR_FILE) && !dest_bit
        |=> acc_ff == ($past(acc_ff) | $past(i_file_rdata)) && zero_ff == (acc_ff == 8'h00))
        else $error("or file result wrong");

    a_move_fw: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ9
        !flush_ff && op_is(i_instr, `IDE_OP_MOVE_FW) && !dest_bit
        |=> acc_ff == $past(i_file_rdata) && $stable(zero_ff))
        else $error("file move wrong");

    a_load_lit: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ10
        !flush_ff && op_is(i_instr, `IDE_OP_LOAD_LIT) |=> acc_ff == $past(i_instr[7:0]))
        else $error("literal load wrong");

    a_store_file: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ11
        !flush_ff && op_is(i_instr, `IDE_OP_STORE) && dest_bit
        |=> fwr_ff.we && fwr_ff.addr == $past(i_instr[6:0]) && fwr_ff.data == $past(acc_ff))
        else $error("store to file wrong");

    a_store_spec: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ12
        !flush_ff && i_instr[13:6] == 8'h00
        |=> swr_ff.we && swr_ff.addr == $past(i_instr[5:0]) && !fwr_ff.we)
        else $error("store to special register wrong");

    a_flag_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ14
        flush_ff || op_is(i_instr, `IDE_OP_LOAD_LIT) || op_is(i_instr, `IDE_OP_INC_SKIP)
        |=> $stable(zero_ff))
        else $error("flag changed by flagless instruction");

    a_skip_slot_step: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ2
        flush_ff && !jump_hold_ff |=> pc_ff == $past(pc_ff) + `IDE_PC_STEP)
        else $error("skip slot did not step counter by one");

    a_flush_no_effect: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ2
        flush_ff |=> !fwr_ff.we && !swr_ff.we && acc_ff == $past(acc_ff))
        else $error("discarded slot changed state");

    a_inc_skip_file: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ3
        !flush_ff && op_is(i_instr, `IDE_OP_INC_SKIP) && dest_bit
        |=> fwr_ff.we && fwr_ff.data == 8'($past(i_file_rdata) + `IDE_ONE))
        else $error("increment skip file result wrong");

    a_dec_to_acc: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ1
        !flush_ff && op_is(i_instr, `IDE_OP_DEC_SKIP) && !dest_bit
        |=> acc_ff == 8'($past(i_file_rdata) - `IDE_ONE) && !fwr_ff.we)
        else $error("decrement skip accumulator result wrong");

    a_store_no_flag: assert property (@(posedge i_sys_clk) disable iff (i_srst) // RQ11
        !flush_ff && op_is(i_instr, `IDE_OP_STORE)
        |=> $stable(zero_ff) && $stable(acc_ff))
        else $error("store changed accumulator or flag");
endmodule : ide_core
`default_nettype wire

// file: dv/ide_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ide_mem_model
    import ide_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic [11:0] i_pc,
    input wire logic [6:0] i_file_raddr,
    input wire ide_pkg::ide_file_wr_t i_file_wr,
    input wire ide_pkg::ide_spec_wr_t i_spec_wr,
    output logic [13:0] o_instr,
    output logic [7:0] o_file_rdata
);
    logic [13:0] prog_mem [4096];
    logic [7:0] file_mem [128];
    logic [7:0] spec_mem [64];
    assign o_instr = prog_mem[i_pc];
    // a write still in flight is forwarded, so back-to-back reads see fresh data
    assign o_file_rdata = (i_file_wr.we && i_file_wr.addr == i_file_raddr) ?
        i_file_wr.data : file_mem[i_file_raddr];
    always @(posedge i_sys_clk) begin
        if (i_file_wr.we) begin
            file_mem[i_file_wr.addr] <= i_file_wr.data;
        end
        if (i_spec_wr.we) begin
            spec_mem[i_spec_wr.addr] <= i_spec_wr.data;
        end
    end
endmodule : ide_mem_model
`default_nettype wire

// file: dv/mcu_instr_decode_exec_subset_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_instr_decode_exec_subset_tb_top;
    import ide_pkg::*;
    localparam logic [13:0] LD = 14'h1900;
    localparam logic [13:0] ORL = 14'h1a00;
    localparam logic [13:0] ORF = 14'h0400;
    localparam logic [13:0] INC = 14'h0a00;
    localparam logic [13:0] DSZ = 14'h0b00;
    localparam logic [13:0] ISZ = 14'h0f00;
    localparam logic [13:0] MFA = 14'h0800;
    localparam logic [13:0] STF = 14'h0080;
    localparam logic [13:0] STS = 14'h0000;
    localparam logic [13:0] JMP = 14'h3000;
    localparam logic [13:0] DST = 14'h0080;
    // rotate is outside this block's set, so it idles the core without side effects
    localparam logic [13:0] IDLE = 14'h0d00;
    localparam int LIMIT = 2000;
    logic sys_clk;
    logic srst;
    logic [13:0] instr;
    logic [7:0] rdata;
    logic [7:0] acc;
    logic [6:0] raddr;
    ide_file_wr_t file_wr;
    ide_spec_wr_t spec_wr;
    logic [11:0] pc;
    logic zero_flag;
    logic flush;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycle_cnt = 0;
    ide_core u_dut (.i_sys_clk(sys_clk), .i_srst(srst), .i_instr(instr),
        .i_file_rdata(rdata), .o_file_raddr(raddr), .o_file_wr(file_wr),
        .o_spec_wr(spec_wr), .o_pc(pc), .o_acc(acc), .o_zero_flag(zero_flag),
        .o_flush(flush));
    ide_mem_model u_mem (.i_sys_clk(sys_clk), .i_pc(pc), .i_file_raddr(raddr),
        .i_file_wr(file_wr), .i_spec_wr(spec_wr), .o_instr(instr), .o_file_rdata(rdata));
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    always @(posedge sys_clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == LIMIT) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic run(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : run
    // program is preloaded before boot holds the core in reset for two cycles
    task automatic boot;
        srst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'h0;
    endtask : boot
    task automatic wipe;
        for (int i = 0; i < 4096; i++) u_mem.prog_mem[i] = IDLE;
    endtask : wipe
    task automatic t_moves;
        wipe();
        u_mem.prog_mem[0] = ORL;
        u_mem.prog_mem[1] = LD | 14'h005a;
        u_mem.prog_mem[2] = STF | 14'h007f;
        u_mem.prog_mem[3] = STS | 14'h003f;
        u_mem.prog_mem[4] = LD | 14'h003c;
        u_mem.prog_mem[5] = MFA | 14'h007f;
        u_mem.prog_mem[6] = JMP | 14'h0006;
        boot();
        run(1); chk(16'(zero_flag), 16'h0001);
        run(1); chk(16'(acc), 16'h005a);
        chk(16'(zero_flag), 16'h0001);
        run(1); chk(16'(file_wr), {1'h1, 7'h7f, 8'h5a});
        run(1); chk(16'(spec_wr), {1'h0, 1'h1, 6'h3f, 8'h5a});
        run(2); chk(16'(acc), 16'h005a);
        chk(16'(zero_flag), 16'h0001);
        chk(16'(u_mem.spec_mem[63]), 16'h005a);
        $display("test moves done");
    endtask : t_moves
    task automatic t_arith;
        wipe();
        u_mem.file_mem[16] = 8'hff;
        u_mem.file_mem[17] = 8'hc0;
        u_mem.prog_mem[0] = LD | 14'h000f;
        u_mem.prog_mem[1] = INC | DST | 14'h0010;
        u_mem.prog_mem[2] = INC | 14'h0011;
        u_mem.prog_mem[3] = ORF | DST | 14'h0011;
        u_mem.prog_mem[4] = ORL | 14'h0002;
        u_mem.prog_mem[5] = ISZ | DST | 14'h0010;
        u_mem.prog_mem[6] = JMP | 14'h0006;
        boot();
        run(2); chk(16'(file_wr), {1'h1, 7'h10, 8'h00});
        chk(16'(zero_flag), 16'h0001);
        run(1); chk(16'(acc), 16'h00c1);
        chk(16'(zero_flag), 16'h0000);
        run(1); chk(16'(file_wr), {1'h1, 7'h11, 8'hc1});
        run(1); chk(16'(acc), 16'h00c3);
        chk(16'(u_mem.file_mem[17]), 16'h00c1);
        run(1); chk(16'(file_wr), {1'h1, 7'h10, 8'h01});
        chk(16'(zero_flag), 16'h0000);
        $display("test arith done");
    endtask : t_arith
    task automatic t_skip;
        wipe();
        u_mem.file_mem[32] = 8'h01;
        u_mem.file_mem[33] = 8'hff;
        u_mem.file_mem[34] = 8'h05;
        u_mem.prog_mem[0] = ORL;
        u_mem.prog_mem[1] = DSZ | DST | 14'h0020;
        u_mem.prog_mem[2] = LD | 14'h0011;
        u_mem.prog_mem[3] = ISZ | 14'h0021;
        u_mem.prog_mem[4] = LD | 14'h0022;
        u_mem.prog_mem[5] = DSZ | 14'h0022;
        u_mem.prog_mem[6] = ORL | 14'h0040;
        u_mem.prog_mem[7] = JMP | 14'h0007;
        boot();
        run(2); chk(16'(flush), 16'h0001);
        chk(16'(file_wr), {1'h1, 7'h20, 8'h00});
        run(2); chk(16'(flush), 16'h0001);
        chk(16'(acc), 16'h0000);
        run(2); chk(16'(acc), 16'h0004);
        chk(16'(flush), 16'h0000);
        chk(16'(zero_flag), 16'h0001);
        run(1); chk(16'(acc), 16'h0044);
        chk(16'(u_mem.file_mem[33]), 16'h00ff);
        $display("test skip done");
    endtask : t_skip
    task automatic t_jump;
        wipe();
        u_mem.prog_mem[0] = JMP | 14'h0fff;
        u_mem.prog_mem[4095] = LD | 14'h0077;
        boot();
        run(1); chk(16'(pc), 16'h0fff);
        chk(16'(flush), 16'h0001);
        run(1); chk(16'(pc), 16'h0fff);
        chk(16'(flush), 16'h0000);
        run(2); chk(16'(acc), 16'h0077);
        $display("test jump done");
    endtask : t_jump
    initial begin
        srst = 1'h1;
        repeat (20) @(posedge sys_clk);
        #1;
        t_moves();
        t_arith();
        t_skip();
        t_jump();
        end_sim();
    end
endmodule : mcu_instr_decode_exec_subset_tb_top
`default_nettype wire
